/* File: hdl/rcd_defs.svh */
// constants of the small risc core datapath: offsets, fields, codes, counts
// assumes inclusion by rcd_core and rcd_core_test; definitions only
`ifndef RCD_DEFS_SVH
`define RCD_DEFS_SVH

// ***********************************************************
// widths and sizes
// ***********************************************************
`define RCD_IW 12
`define RCD_DW 8
`define RCD_PCW 10
`define RCD_RAM_DEPTH 72
`define RCD_PORTW 6
`define RCD_TCY_NS 25
`define RCD_BRANCH_CYC 2

// ***********************************************************
// data space map
// ***********************************************************
`define RCD_FA_INDF 7'h00
`define RCD_FA_PCL 7'h02
`define RCD_FA_STAT 7'h03
`define RCD_FA_FSR 7'h04
`define RCD_FA_PORT 7'h05
`define RCD_FA_DIR 7'h06
`define RCD_FA_RAM 7'h07

// ***********************************************************
// status bits and reset values
// ***********************************************************
`define RCD_ST_C 0
`define RCD_ST_DC 1
`define RCD_ST_Z 2
`define RCD_STAT_RST 8'h18
`define RCD_PC_RST 10'h000
`define RCD_DIR_RST 6'h3F

// ***********************************************************
// opcodes, bits 11:8
// ***********************************************************
`define RCD_OP_MOVWF 4'h0
`define RCD_OP_ADD 4'h1
`define RCD_OP_SUB 4'h2
`define RCD_OP_AND 4'h3
`define RCD_OP_IOR 4'h4
`define RCD_OP_XOR 4'h5
`define RCD_OP_RLF 4'h6
`define RCD_OP_RRF 4'h7
`define RCD_OP_INC 4'h8
`define RCD_OP_MOVF 4'h9
`define RCD_OP_DECSZ 4'hA
`define RCD_OP_MOVLW 4'hB
`define RCD_OP_ADDLW 4'hC
`define RCD_OP_ANDLW 4'hD
`define RCD_OP_XORLW 4'hE
`define RCD_OP_GOTO 4'hF

// ***********************************************************
// register port
// ***********************************************************
`define RCD_RA_CFG 2'h0
`define RCD_RA_OPT 2'h1
`define RCD_RA_STAT 2'h2
`define RCD_RA_ACC 2'h3
`define RCD_CFG_RST 4'h6
`define RCD_OPT_RST 2'h0
`define RCD_CFG_EXTERNAL_RESET_PIN 2
`define RCD_CFG_INSTRUCTION_RATE_OUTPUT 3
`define RCD_OPT_PULL 0
`define RCD_OPT_WAKE 1

`endif

/* File: hdl/rcd_pkg.sv */
// types of the small risc core datapath
// assumes nothing beyond a systemverilog compiler
package rcd_pkg;
    typedef enum logic [1:0] {RCD_OSC_LP, RCD_OSC_XT, RCD_OSC_INTRC, RCD_OSC_EXTRC} rcd_osc_t;
    typedef enum logic [3:0] {
        RCD_ALU_PASSA, RCD_ALU_LOAD, RCD_ALU_PASSB, RCD_ALU_ADD, RCD_ALU_SUB,
        RCD_ALU_AND, RCD_ALU_IOR, RCD_ALU_XOR, RCD_ALU_RL, RCD_ALU_RR,
        RCD_ALU_INC, RCD_ALU_DEC, RCD_ALU_CLR
    } rcd_alu_t;
    typedef enum logic {RCD_RUN, RCD_SLEEP} rcd_state_t;
endpackage

/* File: hdl/rcd_alu_if.sv */
// operand and result bundle between core and alu
// assumes rcd_pkg compiled first
`timescale 1ns/100ps
interface rcd_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    rcd_pkg::rcd_alu_t op;
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    modport core (output a, b, cin, op, input res, c, dc, z, upd_c, upd_dc, upd_z);
    modport alu (input a, b, cin, op, output res, c, dc, z, upd_c, upd_dc, upd_z);
endinterface

/* File: hdl/rcd_alu.sv */
// 8-bit combinational alu with flag outputs
// assumes operands settle within one mclk period
`timescale 1ns/100ps
module rcd_alu
(
    // operands and results
    rcd_alu_if.alu x
);
    logic [8:0] sum;
    logic [4:0] nib;

    // ***********************************************************
    // operation select
    // ***********************************************************
    always_comb
    begin
        sum = 9'h000;
        nib = 5'h00;
        x.upd_c = 1'b0;
        x.upd_dc = 1'b0;
        x.upd_z = 1'b1;
        x.c = x.cin;
        case (x.op)
            rcd_pkg::RCD_ALU_ADD:
            begin
                sum = {1'b0, x.a} + {1'b0, x.b};
                nib = {1'b0, x.a[3:0]} + {1'b0, x.b[3:0]};
                x.upd_c = 1'b1;
                x.upd_dc = 1'b1;
            end
            rcd_pkg::RCD_ALU_SUB:
            begin
                sum = {1'b0, x.b} + {1'b0, ~x.a} + 9'h001;
                nib = {1'b0, x.b[3:0]} + {1'b0, ~x.a[3:0]} + 5'h01;
                x.upd_c = 1'b1;
                x.upd_dc = 1'b1;
            end
            rcd_pkg::RCD_ALU_AND: sum = {1'b0, x.a & x.b};
            rcd_pkg::RCD_ALU_IOR: sum = {1'b0, x.a | x.b};
            rcd_pkg::RCD_ALU_XOR: sum = {1'b0, x.a ^ x.b};
            rcd_pkg::RCD_ALU_RL:
            begin
                sum = {x.b, x.cin};
                x.upd_c = 1'b1;
                x.upd_z = 1'b0;
            end
            rcd_pkg::RCD_ALU_RR:
            begin
                sum = {x.b[0], x.cin, x.b[7:1]};
                x.upd_c = 1'b1;
                x.upd_z = 1'b0;
            end
            rcd_pkg::RCD_ALU_INC: sum = {1'b0, x.b + 8'h01};
            rcd_pkg::RCD_ALU_DEC:
            begin
                sum = {1'b0, x.b - 8'h01};
                x.upd_z = 1'b0;
            end
            rcd_pkg::RCD_ALU_PASSB: sum = {1'b0, x.b};
            rcd_pkg::RCD_ALU_CLR: sum = 9'h000;
            rcd_pkg::RCD_ALU_PASSA:
            begin
                sum = {1'b0, x.a};
                x.upd_z = 1'b0;
            end
            default:
            begin
                sum = {1'b0, x.b};
                x.upd_z = 1'b0;
            end
        endcase
        if (x.upd_c)
        begin
            x.c = sum[8];
        end
    end

    assign x.res = sum[7:0];
    assign x.dc = nib[4];
    assign x.z = (sum[7:0] == 8'h00);
endmodule

/* File: hdl/rcd_core.sv */
// small risc core datapath: fetch, decode, alu, data space, pins, options
// assumes a combinational program memory and mclk equal to the instruction clock
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
`include "rcd_defs.svh"
module rcd_core
#(
    parameter int PCW = `RCD_PCW,
    parameter int RAM_DEPTH = `RCD_RAM_DEPTH
)
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // program bus
    output logic [PCW-1:0] prog_addr,
    input wire logic [`RCD_IW-1:0] prog_data,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // port pins
    input wire logic [`RCD_PORTW-1:0] pin_in,
    output logic [`RCD_PORTW-1:0] pin_out,
    output logic [`RCD_PORTW-1:0] pin_oe,
    output logic [`RCD_PORTW-1:0] pin_pull_en,
    // core state
    output logic sleeping
);
    localparam logic [6:0] RAM_END = 7'(`RCD_FA_RAM + RAM_DEPTH);

    // ***********************************************************
    // state
    // ***********************************************************
    logic [PCW-1:0] pc;
    logic [`RCD_IW-1:0] ir;
    logic ir_vld;
    logic [7:0] w;
    logic [7:0] stat;
    logic [7:0] fsr;
    logic [5:0] port_lat;
    logic [5:0] port_dir;
    logic [7:0] ram [RAM_DEPTH];
    rcd_pkg::rcd_state_t run_st;
    logic [2:0] wake_ref;
    logic ck_tgl;
    logic [3:0] cfg;
    logic [1:0] opt;

    rcd_alu_if alu_x ();

    rcd_alu u_alu
    (
        .x(alu_x)
    );

    // ***********************************************************
    // options and device reset
    // ***********************************************************
    wire external_reset_pin_en = cfg[`RCD_CFG_EXTERNAL_RESET_PIN];
    wire instruction_rate_output_en = cfg[`RCD_CFG_INSTRUCTION_RATE_OUTPUT];
    wire rcd_pkg::rcd_osc_t osc_mode = rcd_pkg::rcd_osc_t'(cfg[1:0]);
    wire crystal = (osc_mode == rcd_pkg::RCD_OSC_LP) || (osc_mode == rcd_pkg::RCD_OSC_XT);
    wire pull_on = opt[`RCD_OPT_PULL];
    wire wake_on = opt[`RCD_OPT_WAKE];
    wire dev_rst = !rst_n || (external_reset_pin_en && !pin_in[3]);

    // ***********************************************************
    // decode
    // ***********************************************************
    wire [3:0] op = ir[11:8];
    wire dst_f = ir[7];
    wire [6:0] fa = ir[6:0];
    wire [7:0] lit = ir[7:0];
    wire running = (run_st == rcd_pkg::RCD_RUN);
    wire ex = ir_vld && running && ce;
    wire is_goto = (op == `RCD_OP_GOTO);
    wire is_skip = (op == `RCD_OP_DECSZ);
    wire is_sleep = (op == `RCD_OP_MOVWF) && !dst_f && fa[0];
    wire is_lit = (op == `RCD_OP_MOVLW) || (op == `RCD_OP_ADDLW)
        || (op == `RCD_OP_ANDLW) || (op == `RCD_OP_XORLW);
    wire [6:0] ea = (fa == `RCD_FA_INDF) ? fsr[6:0] : fa;
    wire ram_hit = (ea >= `RCD_FA_RAM) && (ea < RAM_END);
    wire [6:0] ram_idx = ea - `RCD_FA_RAM;

    // ***********************************************************
    // file read, special registers in data space
    // ***********************************************************
    wire [7:0] fdata =
        (ea == `RCD_FA_PCL) ? pc[7:0] :
        (ea == `RCD_FA_STAT) ? stat :
        (ea == `RCD_FA_FSR) ? fsr :
        (ea == `RCD_FA_PORT) ? {2'b00, pin_in} :
        (ea == `RCD_FA_DIR) ? {2'b00, port_dir} :
        ram_hit ? ram[ram_idx] : 8'h00;

    function automatic rcd_pkg::rcd_alu_t alu_sel(input logic [3:0] opc, input logic d);
        case (opc)
            `RCD_OP_MOVWF: alu_sel = d ? rcd_pkg::RCD_ALU_PASSA : rcd_pkg::RCD_ALU_CLR;
            `RCD_OP_ADD: alu_sel = rcd_pkg::RCD_ALU_ADD;
            `RCD_OP_SUB: alu_sel = rcd_pkg::RCD_ALU_SUB;
            `RCD_OP_AND: alu_sel = rcd_pkg::RCD_ALU_AND;
            `RCD_OP_IOR: alu_sel = rcd_pkg::RCD_ALU_IOR;
            `RCD_OP_XOR: alu_sel = rcd_pkg::RCD_ALU_XOR;
            `RCD_OP_RLF: alu_sel = rcd_pkg::RCD_ALU_RL;
            `RCD_OP_RRF: alu_sel = rcd_pkg::RCD_ALU_RR;
            `RCD_OP_INC: alu_sel = rcd_pkg::RCD_ALU_INC;
            `RCD_OP_MOVF: alu_sel = rcd_pkg::RCD_ALU_PASSB;
            `RCD_OP_DECSZ: alu_sel = rcd_pkg::RCD_ALU_DEC;
            `RCD_OP_ADDLW: alu_sel = rcd_pkg::RCD_ALU_ADD;
            `RCD_OP_ANDLW: alu_sel = rcd_pkg::RCD_ALU_AND;
            `RCD_OP_XORLW: alu_sel = rcd_pkg::RCD_ALU_XOR;
            default: alu_sel = rcd_pkg::RCD_ALU_LOAD;
        endcase
    endfunction

    // ***********************************************************
    // alu operands and write-back
    // ***********************************************************
    assign alu_x.a = w;
    assign alu_x.b = is_lit ? lit : fdata;
    assign alu_x.cin = stat[`RCD_ST_C];
    assign alu_x.op = alu_sel(op, dst_f);

    wire [7:0] res = alu_x.res;
    wire wr_w = ex && !is_goto && !is_sleep && (is_lit || !dst_f);
    wire wr_f = ex && !is_goto && !is_lit && dst_f;
    wire stat_wr = wr_f && (ea == `RCD_FA_STAT);
    wire [7:0] stat_base = stat_wr ? res : stat;
    wire upd_c = ex && alu_x.upd_c && !is_lit;
    wire upd_dc = ex && alu_x.upd_dc && !is_lit;
    wire upd_z = ex && alu_x.upd_z && (op != `RCD_OP_MOVLW);
    wire [7:0] next_stat = {stat_base[7:3],
        upd_z ? alu_x.z : stat_base[`RCD_ST_Z],
        upd_dc ? alu_x.dc : stat_base[`RCD_ST_DC],
        upd_c ? alu_x.c : stat_base[`RCD_ST_C]};

    // ***********************************************************
    // branch and fetch
    // ***********************************************************
    wire [PCW-1:0] goto_tgt = {pc[PCW-1:8], lit};
    wire [PCW-1:0] pc_inc = pc + PCW'(1);
    wire skip_hit = ex && is_skip && (res == 8'h00);
    wire pcl_wr = wr_f && (ea == `RCD_FA_PCL);
    wire taken = ex && (is_goto || skip_hit || pcl_wr);
    wire [PCW-1:0] next_pc = !taken ? pc_inc :
        is_goto ? goto_tgt :
        skip_hit ? pc_inc : {pc[PCW-1:8], res};

    always_ff @(posedge mclk)
    begin
        if (dev_rst)
        begin
            pc <= `RCD_PC_RST;
            ir <= 12'h000;
            ir_vld <= 1'b0;
        end
        else if (ce && running)
        begin
            pc <= next_pc;
            ir <= prog_data;
            ir_vld <= !taken;
        end
    end

    assign prog_addr = pc;

    // ***********************************************************
    // accumulator, status, pointer, port latches
    // ***********************************************************
    always_ff @(posedge mclk)
    begin
        if (dev_rst)
        begin
            w <= 8'h00;
            stat <= `RCD_STAT_RST;
            fsr <= 8'h00;
            port_lat <= 6'h00;
            port_dir <= `RCD_DIR_RST;
        end
        else if (ce)
        begin
            if (wr_w)
                w <= res;
            stat <= next_stat;
            if (wr_f && (ea == `RCD_FA_FSR))
                fsr <= res;
            if (wr_f && (ea == `RCD_FA_PORT))
                port_lat <= res[5:0];
            if (wr_f && (ea == `RCD_FA_DIR))
                port_dir <= res[5:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (ce && wr_f && ram_hit)
            ram[ram_idx] <= res;
    end

    // ***********************************************************
    // sleep and wake on change
    // ***********************************************************
    wire [2:0] wake_now = {pin_in[3], pin_in[1], pin_in[0]};
    wire wake = wake_on && (wake_now != wake_ref);

    always_ff @(posedge mclk)
    begin
        if (dev_rst)
        begin
            run_st <= rcd_pkg::RCD_RUN;
            wake_ref <= 3'h0;
        end
        else if (ce)
        begin
            case (run_st)
                rcd_pkg::RCD_RUN:
                    if (ex && is_sleep)
                    begin
                        run_st <= rcd_pkg::RCD_SLEEP;
                        wake_ref <= wake_now;
                    end
                rcd_pkg::RCD_SLEEP:
                    if (wake)
                        run_st <= rcd_pkg::RCD_RUN;
                default: run_st <= rcd_pkg::RCD_RUN;
            endcase
        end
    end

    assign sleeping = (run_st == rcd_pkg::RCD_SLEEP);

    // ***********************************************************
    // instruction rate output
    // ***********************************************************
    always_ff @(posedge mclk)
    begin
        if (dev_rst)
            ck_tgl <= 1'b0;
        else if (ce)
            ck_tgl <= ~ck_tgl;
    end

    // ***********************************************************
    // pins
    // ***********************************************************
    wire osc_gpio = !crystal;
    wire clk_drive = osc_gpio && instruction_rate_output_en;
    assign pin_out = {port_lat[5], clk_drive ? ck_tgl : port_lat[4], 1'b0, port_lat[2:0]};
    assign pin_oe[0] = !port_dir[0];
    assign pin_oe[1] = !port_dir[1];
    assign pin_oe[2] = !port_dir[2];
    assign pin_oe[3] = 1'b0;
    assign pin_oe[4] = osc_gpio && (instruction_rate_output_en || !port_dir[4]);
    assign pin_oe[5] = osc_gpio && !port_dir[5];
    assign pin_pull_en = {2'b00, external_reset_pin_en || pull_on, 1'b0, pull_on, pull_on};

    // ***********************************************************
    // register port
    // ***********************************************************
    wire [15:0] rd_mux =
        (reg_addr == `RCD_RA_CFG) ? {12'h000, cfg} :
        (reg_addr == `RCD_RA_OPT) ? {14'h0000, opt} :
        (reg_addr == `RCD_RA_STAT) ? {7'h00, sleeping, stat} :
        {8'h00, w};

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cfg <= `RCD_CFG_RST;
            opt <= `RCD_OPT_RST;
            reg_rdata <= 16'h0000;
        end
        else if (ce)
        begin
            if (reg_wr && (reg_addr == `RCD_RA_CFG))
                cfg <= reg_wdata[3:0];
            if (reg_wr && (reg_addr == `RCD_RA_OPT))
                opt <= reg_wdata[1:0];
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    wire sub_nb = (fdata >= w);
    wire z_ref = (res == 8'h00);

    pc_step_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (!dev_rst && ce && running && !taken) |=> (pc == $past(pc_inc)))
    else $error("pc did not advance by one");

    branch_flush_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (ex && taken) |=> !ir_vld ##1 (ir_vld || !$past(ce) || !$past(running)))
    else $error("taken branch did not refill in one cycle");

    goto_tgt_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (ex && is_goto) |=> (pc == $past(goto_tgt)))
    else $error("goto target wrong");

    sub_carry_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (ex && (op == `RCD_OP_SUB) && !stat_wr) |=> (stat[`RCD_ST_C] == $past(sub_nb)))
    else $error("subtract carry is not inverted borrow");

    zero_flag_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (upd_z && !stat_wr) |=> (stat[`RCD_ST_Z] == $past(z_ref)))
    else $error("zero flag wrong");

    acc_hold_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (!wr_w) |=> $stable(w))
    else $error("accumulator changed without a write");

    single_cycle_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (ex && !taken && !is_sleep) |=> ir_vld)
    else $error("instruction took more than one cycle");

    reset_pin_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
        (external_reset_pin_en && !pin_in[3]) |=> (pc == `RCD_PC_RST) && !ir_vld)
    else $error("reset pin did not reset the core");

    pull_external_reset_pin_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
        external_reset_pin_en |-> pin_pull_en[3] && !pin_oe[3])
    else $error("reset pin pull-up off");

    osc_pin_a:
    assert property (@(posedge mclk) disable iff (!rst_n)
        crystal |-> !pin_oe[4] && !pin_oe[5])
    else $error("oscillator pins driven in crystal mode");

    wake_a:
    assert property (@(posedge mclk) disable iff (dev_rst)
        (sleeping && ce && wake) |=> !sleeping)
    else $error("no wake on pin change");
endmodule

/* File: tb/rcd_prog_mem.sv */
// program memory model: combinational words for the fetch port
// assumes the bench loads words before it releases reset
`timescale 1ns/100ps
module rcd_prog_mem
(
    // fetch port
    input wire logic [9:0] addr,
    output logic [11:0] data
);
    // ***********************************************
    // storage, 1024 words of 12 bits
    // ***********************************************
    logic [11:0] mem [0:1023];
    assign data = mem[addr];
endmodule

/* File: tb/rcd_core_test.sv */
// bench of the core: random alu programs, pin options, reset pin
// assumes rcd_pkg, rcd_alu_if, rcd_alu, rcd_core compiled first
`timescale 1ns/100ps
`include "rcd_defs.svh"
module rcd_core_test;
    // ***********************************************
    // signals
    // ***********************************************
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [5:0] pin_in = 6'h3F;
    logic [9:0] prog_addr;
    logic [11:0] prog_data;
    logic [15:0] reg_rdata;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [5:0] pin_pull_en;
    logic sleeping;
    int num_errors = 0;
    int checked = 0;
    int seed = 32'hf372;
    int i;
    int k;
    logic [15:0] rd;
    logic [7:0] x;
    logic [7:0] y;
    logic [3:0] op;
    logic [10:0] e;
    logic t;
    logic [3:0] ops [0:4] = '{`RCD_OP_ADD, `RCD_OP_SUB, `RCD_OP_AND, `RCD_OP_IOR, `RCD_OP_XOR};
    always #12.5 mclk = ~mclk;
    rcd_core #(.PCW(10), .RAM_DEPTH(72)) u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .prog_addr(prog_addr), .prog_data(prog_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
        .sleeping(sleeping));
    rcd_prog_mem u_mem (.addr(prog_addr), .data(prog_data));
    // ***********************************************
    // tasks and expectations
    // ***********************************************
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task reg_read(input logic [1:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task do_reset;
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    task stop_test;
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // result {z, dc, c, w} of file a against accumulator b
    function logic [10:0] alu_expect(input logic [3:0] o, input logic [7:0] a,
        input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] n;
        logic c;
        logic dc;
        c = 1'b0;
        dc = 1'b0;
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        case (o)
            `RCD_OP_ADD:
            begin
                s = {1'b0, a} + {1'b0, b};
                c = s[8];
                dc = n[4];
            end
            `RCD_OP_SUB:
            begin
                s = {1'b0, a - b};
                c = a >= b;
                dc = a[3:0] >= b[3:0];
            end
            `RCD_OP_AND: s = {1'b0, a & b};
            `RCD_OP_IOR: s = {1'b0, a | b};
            default: s = {1'b0, a ^ b};
        endcase
        return {s[7:0] == 8'h00, dc, c, s[7:0]};
    endfunction
    // ***********************************************
    // main sequence
    // ***********************************************
    initial
    begin
        for (i = 0; i < 1024; i++)
            u_mem.mem[i] = {`RCD_OP_GOTO, 8'h04};
        do_reset;
        reg_read(`RCD_RA_CFG, rd);
        check(rd, {12'h000, `RCD_CFG_RST});
        check({10'h000, pin_pull_en}, 16'h0008);
        reg_write(`RCD_RA_OPT, 16'h0001);
        #1 check({10'h000, pin_pull_en}, 16'h000B);
        for (i = 0; i < 4; i++)
        begin
            reg_write(`RCD_RA_CFG, {12'h000, 2'b10, i[1:0]});
            #1 check({15'h0000, pin_oe[3]}, 16'h0000);
            check({10'h000, pin_pull_en}, 16'h000B);
            if (i < 2)
                check({14'h0000, pin_oe[5:4]}, 16'h0000);
            else
            begin
                t = pin_out[4];
                check({15'h0000, pin_oe[4]}, 16'h0001);
                @(posedge mclk);
                #1 check({15'h0000, pin_out[4]}, {15'h0000, ~t});
            end
        end
        for (i = 0; i < 8; i++)
        begin
            x = 8'($random(seed));
            y = 8'($random(seed));
            op = ops[i % 5];
            if (i == 5)
                {x, y, op} = {8'hFF, 8'h01, `RCD_OP_ADD};
            if (i == 6)
                {x, y, op} = {8'h35, 8'h35, `RCD_OP_SUB};
            if (i == 7)
                {x, y, op} = {8'h10, 8'h01, `RCD_OP_SUB};
            u_mem.mem[0] = {`RCD_OP_MOVLW, x};
            u_mem.mem[1] = {`RCD_OP_MOVWF, 1'b1, `RCD_FA_RAM};
            u_mem.mem[2] = {`RCD_OP_MOVLW, y};
            u_mem.mem[3] = {op, 1'b0, `RCD_FA_RAM};
            @(posedge mclk);
            pin_in <= 6'($random(seed)) | 6'h08;
            do_reset;
            k = 0;
            while (prog_addr !== 10'h003 && k < 20)
            begin
                @(posedge mclk);
                #1 k++;
            end
            for (k = 0; k < 5; k++)
            begin
                @(posedge mclk);
                #1 check({6'h00, prog_addr}, k[0] ? 16'h0005 : 16'h0004);
            end
            e = alu_expect(op, x, y);
            reg_read(`RCD_RA_ACC, rd);
            check(rd, {8'h00, e[7:0]});
            reg_read(`RCD_RA_STAT, rd);
            check(rd, {8'h00, 5'h03, e[10:8]});
        end
        // indirect store and load, sleep, wake on line 0, enable freeze
        x = 8'($random(seed));
        u_mem.mem[0] = {`RCD_OP_MOVLW, 8'h07};
        u_mem.mem[1] = {`RCD_OP_MOVWF, 1'b1, `RCD_FA_FSR};
        u_mem.mem[2] = {`RCD_OP_MOVLW, x};
        u_mem.mem[3] = {`RCD_OP_MOVWF, 1'b1, `RCD_FA_INDF};
        u_mem.mem[4] = {`RCD_OP_MOVWF, 1'b0, 7'h00};
        u_mem.mem[5] = {`RCD_OP_MOVF, 1'b0, `RCD_FA_INDF};
        u_mem.mem[6] = {`RCD_OP_MOVWF, 1'b0, 7'h01};
        u_mem.mem[7] = {`RCD_OP_GOTO, 8'h07};
        @(posedge mclk);
        pin_in <= 6'h08;
        do_reset;
        reg_write(`RCD_RA_OPT, 16'h0002);
        repeat (10) @(posedge mclk);
        reg_read(`RCD_RA_STAT, rd);
        check({15'h0000, rd[8]}, 16'h0001);
        reg_read(`RCD_RA_ACC, rd);
        check(rd, {8'h00, x});
        check({15'h0000, sleeping}, 16'h0001);
        @(posedge mclk);
        pin_in <= 6'h09;
        repeat (2) @(posedge mclk);
        #1 check({15'h0000, sleeping}, 16'h0000);
        @(posedge mclk);
        ce <= 1'b0;
        #1 rd = {6'h00, prog_addr};
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        #1 check({6'h00, prog_addr}, rd);
        reg_write(`RCD_RA_CFG, 16'h0002);
        pin_in <= 6'h37;
        repeat (4) @(posedge mclk);
        #1 check({15'h0000, prog_addr == 10'h000}, 16'h0000);
        reg_write(`RCD_RA_CFG, 16'h0006);
        repeat (3) @(posedge mclk);
        #1 check({6'h00, prog_addr}, 16'h0000);
        stop_test;
    end
    initial
    begin
        #200000;
        num_errors++;
        stop_test;
    end
endmodule
